/* dv/dec_counter_bench.sv */
// dec_counter_bench - self-checking bench for the dual event counter
// assumes: dec_defs.svh on the include path, dec_pkg compiled first
`timescale 1ns/10ps
`include "dec_defs.svh"

module dec_counter_bench
  import dec_pkg::*;
;
  logic        clock;
  logic        rstn;
  dec_io_req_t io_req;
  logic        pulse_input_a;
  logic        pulse_input_b;
  logic        noise_clock;
  logic [3:0]  io_rdata;
  logic        counting_active;
  int          error_cnt;
  int          samples_checked;
  int          cycles;

  dec_counter u_dec_counter (
    .clock           (clock),
    .rstn            (rstn),
    .io_req          (io_req),
    .pulse_input_a   (pulse_input_a),
    .pulse_input_b   (pulse_input_b),
    .noise_clock     (noise_clock),
    .io_rdata        (io_rdata),
    .counting_active (counting_active)
  );

  dec_pin_model u_dec_pin_model (
    .clock         (clock),
    .pulse_input_a (pulse_input_a),
    .pulse_input_b (pulse_input_b),
    .noise_clock   (noise_clock)
  );

  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // the whole run needs about 4500 cycles, most of it the wrap test
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("ERROR %0t run hung", $time);
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // strobes drop one clock later, so back-to-back calls never collide
  task automatic wr(input logic [11:0] a, input logic [3:0] d);
    io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    io_req.wr = 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(input logic [11:0] a, input logic [3:0] exp, input string what);
    io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 4'h0};
    @(negedge clock);
    io_req.rd = 1'b0;
    @(negedge clock);
    chk({4'h0, io_rdata}, {4'h0, exp}, what);
  endtask

  // no latching between nibbles, so only read while the pins are quiet
  // each pair is read twice and both must agree, since a carry can tear one read
  task automatic rd_cnt(input logic [11:0] lo, input logic [7:0] exp, input string what);
    repeat (2) begin
      rd(lo, exp[3:0], what);
      rd(lo + 12'h001, exp[7:4], what);
    end
  endtask

  task automatic wait_act(input logic v);
    for (int n = 0; n < 40 && counting_active !== v; n++) @(negedge clock);
    chk({7'h0, counting_active}, {7'h0, v}, "run sync");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 6; i++) rd(`DEC_ADDR_A_LO + 12'(i), 4'h0, "reset");
    $display("reset values done");
  endtask

  task automatic t_start;
    @(posedge noise_clock);
    @(negedge clock);
    wr(`DEC_ADDR_CTRL, 4'hf);
    chk({7'h0, counting_active}, 8'h00, "early run");
    wait_act(1'b1);
    rd(`DEC_ADDR_CTRL, 4'hc, "ctrl");
    repeat (3) u_dec_pin_model.pulse(1'b1, 1'b0);
    repeat (2) u_dec_pin_model.pulse(1'b1, 1'b1);
    rd_cnt(`DEC_ADDR_A_LO, 8'h05, "sep a");
    rd_cnt(`DEC_ADDR_B_LO, 8'h02, "sep b");
    $display("separate count done");
  endtask

  task automatic t_ro;
    for (int i = 0; i < 4; i++) wr(`DEC_ADDR_A_LO + 12'(i), 4'hf);
    rd_cnt(`DEC_ADDR_A_LO, 8'h05, "ro a");
    rd_cnt(`DEC_ADDR_B_LO, 8'h02, "ro b");
    rd(12'h2fd, 4'h0, "unmapped");
    $display("read-only done");
  endtask

  task automatic t_clear;
    wr(`DEC_ADDR_CTRL, 4'hc);
    rd_cnt(`DEC_ADDR_A_LO, 8'h05, "clr0 a");
    rd_cnt(`DEC_ADDR_B_LO, 8'h02, "clr0 b");
    wr(`DEC_ADDR_CTRL, 4'hd);
    rd_cnt(`DEC_ADDR_A_LO, 8'h00, "clr a");
    rd_cnt(`DEC_ADDR_B_LO, 8'h02, "keep b");
    wr(`DEC_ADDR_CTRL, 4'he);
    rd_cnt(`DEC_ADDR_B_LO, 8'h00, "clr b");
    $display("clear done");
  endtask

  task automatic t_wrap;
    repeat (255) u_dec_pin_model.pulse(1'b1, 1'b0);
    rd_cnt(`DEC_ADDR_A_LO, 8'hff, "full");
    u_dec_pin_model.pulse(1'b1, 1'b0);
    rd_cnt(`DEC_ADDR_A_LO, 8'h00, "wrap");
    $display("wrap done");
  endtask

  task automatic t_phase;
    wr(`DEC_ADDR_CTRL, 4'h7);
    rd(`DEC_ADDR_CTRL, 4'h4, "phase ctrl");
    repeat (2) u_dec_pin_model.quad(1'b1);
    u_dec_pin_model.quad(1'b0);
    rd_cnt(`DEC_ADDR_A_LO, 8'h02, "phase a");
    rd_cnt(`DEC_ADDR_B_LO, 8'h01, "phase b");
    $display("phase done");
  endtask

  task automatic t_stop;
    wr(`DEC_ADDR_CTRL, 4'h0);
    wait_act(1'b0);
    u_dec_pin_model.pulse(1'b1, 1'b1);
    rd_cnt(`DEC_ADDR_A_LO, 8'h02, "stop a");
    rd_cnt(`DEC_ADDR_B_LO, 8'h01, "stop b");
    rd(`DEC_ADDR_CTRL, 4'h0, "stop ctrl");
    $display("stop done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    io_req = '0;
    rstn = 1'b0;
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    t_reset();
    t_start();
    t_ro();
    t_clear();
    t_wrap();
    t_phase();
    t_stop();
    end_sim();
  end
endmodule

/* dv/dec_pin_model.sv */
// dec_pin_model - pulse sources on both counter pins and the noise-rejector clock
// assumes: the bench calls its tasks just after a falling edge of clock
`timescale 1ns/10ps

module dec_pin_model (
  input  wire logic clock,
  output logic      pulse_input_a,
  output logic      pulse_input_b,
  output logic      noise_clock
);
  // ----------------------------------------
  // noise-rejector clock
  // ----------------------------------------
  // free running, half period off the clock grid so the phase drifts
  initial begin
    noise_clock = 1'b0;
    forever #85 noise_clock = ~noise_clock;
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  initial begin
    pulse_input_a = 1'b0;
    pulse_input_b = 1'b0;
  end

  // walk a pin pattern {a,b}, 4 clocks per step keeps the rate low
  task automatic walk(input logic [7:0] seq);
    for (int i = 3; i >= 0; i--) begin
      {pulse_input_a, pulse_input_b} = seq[2*i+:2];
      repeat (4) @(negedge clock);
    end
  endtask

  // one pulse on the chosen pins
  task automatic pulse(input logic a, input logic b);
    walk({a, b, a, b, 4'b0000});
  endtask

  // quadrature step, the leading pin rises first
  task automatic quad(input logic lead_a);
    walk(lead_a ? 8'b10_11_01_00 : 8'b01_11_10_00);
  endtask
endmodule

/* inc/dec_defs.svh */
// dec_defs.svh - addresses, bit positions and reset values of the dual event counter
// assumes: a 12-bit nibble-wide i/o memory space on the cpu side
`ifndef DEC_DEFS_SVH
`define DEC_DEFS_SVH

// ----------------------------------------
// i/o addresses
// ----------------------------------------
`define DEC_ADDR_W        12
`define DEC_ADDR_A_LO     12'h2f8
`define DEC_ADDR_A_HI     12'h2f9
`define DEC_ADDR_B_LO     12'h2fa
`define DEC_ADDR_B_HI     12'h2fb
`define DEC_ADDR_CTRL     12'h2fc

// ----------------------------------------
// counter_control bit positions
// ----------------------------------------
`define DEC_BIT_CLR_A     0
`define DEC_BIT_CLR_B     1
`define DEC_BIT_RUN       2
`define DEC_BIT_MODE      3

// ----------------------------------------
// reset values
// ----------------------------------------
`define DEC_CNT_RST       8'h00
`define DEC_NIB_RST       4'h0
`define DEC_RUN_RST       1'b0
`define DEC_MODE_RST      1'b0
`define DEC_MODE_SEP      1'b1

`endif

/* inc/dec_pkg.sv */
// dec_pkg - types shared by the dual event counter files
// assumes: dec_defs.svh is on the include path
`include "dec_defs.svh"

package dec_pkg;

  // ----------------------------------------
  // cpu i/o request and state carriers
  // ----------------------------------------
  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [`DEC_ADDR_W-1:0] addr;
    logic [3:0]             wdata;
  } dec_io_req_t;

  typedef struct packed {
    logic [7:0] cnt_a;
    logic [7:0] cnt_b;
    logic       run;
    logic       run_act;
    logic       mode;
    logic [3:0] rdata;
  } dec_state_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
  } dec_sync_state_t;

endpackage

/* rtl/dec_counter.sv */
// dec_counter - two 8-bit event counters with separate and phase-detection modes
// assumes: cpu i/o strobes are one-cycle pulses on clock; pins and the
// noise-rejector clock are asynchronous and already noise-filtered
//
// Contract
// R1 - counter a is read as a low nibble at 2f8 and a high nibble at 2f9.
// R2 - counter b is read as a low nibble at 2fa and a high nibble at 2fb.
// R3 - counter nibbles are read-only and writes to them never change a count.
// R4 - reset clears both counters to zero.
// R5 - writing one to count_a_clear zeroes counter a, writing zero does nothing.
// R6 - writing one to count_b_clear zeroes counter b, writing zero does nothing.
// R7 - both clear bits are write-only and read as zero.
// R8 - counting_run_control runs or stops counting, reads back, and resets to zero.
// R9 - count_mode_select picks separate (one) or phase (zero), reads back, resets to zero.
// R10 - in phase mode only one counter advances per event, chosen by the input phase.
// R11 - a run or stop takes effect at the next falling edge of the noise-rejector clock.
// R12 - the controlling side allows for the delayed start or stop when pulses arrive.
// R13 - software reads each counter several times and keeps matching values.
// R14 - with software sampling the pulse rate stays at or below oscillator/256.
// R15 - in separate mode each counter counts pulses on its own input.
// R16 - each counter steps by one and wraps from ff to 00.
`timescale 1ns/10ps
`include "dec_defs.svh"

module dec_counter
  import dec_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  dec_io_req_t      io_req,
  input  wire logic        pulse_input_a,
  input  wire logic        pulse_input_b,
  input  wire logic        noise_clock,
  output logic      [3:0]  io_rdata,
  output logic             counting_active
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // 8-bit step with natural wrap
  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = v + 8'h01; // R16
  endfunction

  // read decode of the nibble map
  // unmapped addresses read zero so nothing floats onto the data bus
  function automatic logic [3:0] rd_mux(input logic [`DEC_ADDR_W-1:0] a,
                                        input dec_state_t st);
    case (a)
      `DEC_ADDR_A_LO: rd_mux = st.cnt_a[3:0]; // R1
      `DEC_ADDR_A_HI: rd_mux = st.cnt_a[7:4]; // R1
      `DEC_ADDR_B_LO: rd_mux = st.cnt_b[3:0]; // R2
      `DEC_ADDR_B_HI: rd_mux = st.cnt_b[7:4]; // R2
      `DEC_ADDR_CTRL: rd_mux = {st.mode, st.run, 2'b00}; // R7 R8 R9
      default:        rd_mux = `DEC_NIB_RST;
    endcase
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] lvl;
  logic [2:0] rise;
  logic [2:0] fall;

  // pin a is bit 0, pin b bit 1, noise-rejector clock bit 2
  dec_sync_edge u_sync (
    .clock (clock),
    .rstn  (rstn),
    .pins  ({noise_clock, pulse_input_b, pulse_input_a}),
    .level (lvl),
    .rise  (rise),
    .fall  (fall)
  );

  // run/stop is only applied on a noise-clock fall, so a write that
  // races a burst of pulses still starts or stops on that clock's grid
  logic nr_fall;
  assign nr_fall = fall[2]; // R11

  // ----------------------------------------
  // state
  // ----------------------------------------
  dec_state_t s_q;
  dec_state_t s_d;

  logic ctrl_wr;
  logic clr_a;
  logic clr_b;
  logic ev_a;
  logic ev_b;

  assign ctrl_wr = io_req.wr && (io_req.addr == `DEC_ADDR_CTRL); // R3
  assign clr_a   = ctrl_wr && io_req.wdata[`DEC_BIT_CLR_A];
  assign clr_b   = ctrl_wr && io_req.wdata[`DEC_BIT_CLR_B];

  // event qualification; phase mode leads on a rise of a and samples b
  always_comb begin
    ev_a = 1'b0;
    ev_b = 1'b0;
    if (s_q.run_act) begin // R8
      if (s_q.mode == `DEC_MODE_SEP) begin
        ev_a = rise[0]; // R15
        ev_b = rise[1]; // R15
      end else if (rise[0]) begin
        ev_a = ~lvl[1]; // R10
        ev_b = lvl[1];  // R10
      end
    end
  end

  // next state; a clear overrides an event in the same cycle
  always_comb begin
    s_d = s_q;
    if (ctrl_wr) begin
      s_d.run  = io_req.wdata[`DEC_BIT_RUN];  // R8
      s_d.mode = io_req.wdata[`DEC_BIT_MODE]; // R9
    end
    if (nr_fall) begin
      s_d.run_act = s_q.run; // R11
    end
    // writes to nibble addresses are not decoded, so counts stay put
    if (clr_a) begin
      s_d.cnt_a = `DEC_CNT_RST; // R5
    end else if (ev_a) begin
      s_d.cnt_a = inc8(s_q.cnt_a); // R15 R16
    end
    if (clr_b) begin
      s_d.cnt_b = `DEC_CNT_RST; // R6
    end else if (ev_b) begin
      s_d.cnt_b = inc8(s_q.cnt_b); // R15 R16
    end
    if (io_req.rd) begin
      s_d.rdata = rd_mux(io_req.addr, s_q); // R1 R2
    end
  end

  // async reset loads constants only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q.cnt_a   <= `DEC_CNT_RST; // R4
      s_q.cnt_b   <= `DEC_CNT_RST; // R4
      s_q.run     <= `DEC_RUN_RST;
      s_q.run_act <= `DEC_RUN_RST;
      s_q.mode    <= `DEC_MODE_RST;
      s_q.rdata   <= `DEC_NIB_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign io_rdata        = s_q.rdata;
  assign counting_active = s_q.run_act;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // read checks look one cycle late, because io_rdata is a flop
  // loaded on the edge that takes the read strobe
  chk_clear_a_zero: assert property (@(posedge clock) disable iff (!rstn) // R5
    clr_a |=> (s_q.cnt_a == 8'h00)) else $error("counter a not cleared");

  chk_clear_b_zero: assert property (@(posedge clock) disable iff (!rstn) // R6
    clr_b |=> (s_q.cnt_b == 8'h00)) else $error("counter b not cleared");

  chk_ro_write_ignored: assert property (@(posedge clock) disable iff (!rstn) // R3
    (io_req.wr && io_req.addr >= `DEC_ADDR_A_LO && io_req.addr <= `DEC_ADDR_B_HI
     && !ev_a && !ev_b) |=> $stable(s_q.cnt_a) && $stable(s_q.cnt_b))
    else $error("write changed a count");

  chk_ctrl_readback: assert property (@(posedge clock) disable iff (!rstn) // R8
    (ctrl_wr ##1 (io_req.rd && io_req.addr == `DEC_ADDR_CTRL && !ctrl_wr))
    |=> (io_rdata == {$past(io_req.wdata[3], 2), $past(io_req.wdata[2], 2), 2'b00}))
    else $error("control readback wrong or clear bits nonzero");

  chk_stop_holds: assert property (@(posedge clock) disable iff (!rstn) // R8
    (!s_q.run_act && !ctrl_wr) |=> $stable(s_q.cnt_a) && $stable(s_q.cnt_b))
    else $error("counter moved while stopped");

  chk_run_on_nrfall: assert property (@(posedge clock) disable iff (!rstn) // R11
    $changed(s_q.run_act) |-> $past(nr_fall))
    else $error("run changed away from noise clock fall");

  chk_sep_step: assert property (@(posedge clock) disable iff (!rstn) // R15
    (s_q.run_act && s_q.mode && rise[0] && !clr_a)
    |=> (s_q.cnt_a == $past(s_q.cnt_a) + 8'h01)) else $error("separate step wrong");

  chk_phase_single: assert property (@(posedge clock) disable iff (!rstn) // R10
    (s_q.run_act && !s_q.mode && !ctrl_wr)
    |=> !($changed(s_q.cnt_a) && $changed(s_q.cnt_b)))
    else $error("both counters moved in phase mode");

  chk_read_count_a: assert property (@(posedge clock) disable iff (!rstn) // R1
    (io_req.rd && io_req.addr == `DEC_ADDR_A_HI) |=> (io_rdata == $past(s_q.cnt_a[7:4])))
    else $error("count a high nibble read wrong");

  chk_read_count_b: assert property (@(posedge clock) disable iff (!rstn) // R2
    (io_req.rd && io_req.addr == `DEC_ADDR_B_LO) |=> (io_rdata == $past(s_q.cnt_b[3:0])))
    else $error("count b low nibble read wrong");

  chk_reset_counts_zero: assert property (@(posedge clock) // R4
    !rstn |-> (s_q.cnt_a == `DEC_CNT_RST && s_q.cnt_b == `DEC_CNT_RST && !s_q.run_act))
    else $error("reset left a count or run set");

  chk_clear_bits_zero: assert property (@(posedge clock) disable iff (!rstn) // R7
    (io_req.rd && io_req.addr == `DEC_ADDR_CTRL) |=> (io_rdata[1:0] == 2'b00))
    else $error("clear bits read nonzero");

  chk_mode_write_now: assert property (@(posedge clock) disable iff (!rstn) // R9
    ctrl_wr |=> (s_q.mode == $past(io_req.wdata[`DEC_BIT_MODE])))
    else $error("mode bit not taken from write");

  chk_wrap_to_zero: assert property (@(posedge clock) disable iff (!rstn) // R16
    (s_q.cnt_a == 8'hff && ev_a && !clr_a) |=> (s_q.cnt_a == 8'h00))
    else $error("counter a did not wrap");

  chk_phase_b_alone: assert property (@(posedge clock) disable iff (!rstn) // R10
    (s_q.run_act && !s_q.mode && rise[1] && !rise[0] && !ctrl_wr)
    |=> $stable(s_q.cnt_a) && $stable(s_q.cnt_b)) else $error("b rise alone counted");

  chk_sep_step_b: assert property (@(posedge clock) disable iff (!rstn) // R15
    (s_q.run_act && s_q.mode && rise[1] && !clr_b)
    |=> (s_q.cnt_b == $past(s_q.cnt_b) + 8'h01)) else $error("separate step b wrong");

endmodule

/* rtl/dec_sync_edge.sv */
// dec_sync_edge - two-flop synchronisers with edge detection for the pin inputs
// assumes: inputs are asynchronous pins; edges are seen one to two clocks late
`timescale 1ns/10ps

module dec_sync_edge
  import dec_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [2:0] pins,
  output logic      [2:0] level,
  output logic      [2:0] rise,
  output logic      [2:0] fall
);

  dec_sync_state_t s_q;
  dec_sync_state_t s_d;

  // ----------------------------------------
  // synchroniser chain
  // ----------------------------------------
  // first stage feeds only the second; edges come from stages two and three
  always_comb begin
    s_d    = s_q;
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // edge outputs
  assign level = s_q.s2;
  assign rise  = s_q.s2 & ~s_q.s3;
  assign fall  = ~s_q.s2 & s_q.s3;

  chk_edge_exclusive: assert property (@(posedge clock) disable iff (!rstn)
    (rise & fall) == 3'b000) else $error("rise and fall seen together");

endmodule
